/* rtl/cdb_core.sv */
// Purpose: execution of decrement, decrement-skip, jump and halt
// Assumes: program memory and file read data valid in the same phase as the address
// Notes: one instruction cycle is two core clocks (load, execute)
`timescale 1ns/10ps
`include "cdb_regs.svh"
module cdb_core (
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic [15:0] INSTR_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic [7:0] IRQ_SRC_I,
    input wire logic [7:0] IRQ_EN_I,
    input wire logic GIE_I,
    output logic [12:0] PMEM_ADDR_O,
    output logic [7:0] FILE_ADDR_O,
    output logic [7:0] FILE_WDATA_O,
    output logic FILE_WE_O,
    output logic [7:0] W_O,
    output logic ZERO_O,
    output logic CORE_RUN_O,
    output logic VEC_TAKE_O,
    output logic [12:0] RETURN_ADDR_O,
    output logic INSTR_DONE_O
);
    import cdb_pkg::*;

    cdb_state_t state_q;
    cdb_bubble_t bubble_q;
    logic [15:0] ir_q;
    logic [12:0] pc_q;
    logic wake;
    cdb_op_t op;
    logic [7:0] result;
    logic exec;
    logic live;
    logic dec_op;

    function automatic cdb_op_t decode(input logic [15:0] w);
        cdb_op_t o;
        o = CDB_OP_NOP;
        if (w[`CDB_JMP_HI:`CDB_JMP_LO] == `CDB_OPC_JMP) begin
            o = CDB_OP_JMP;
        end else if (w == `CDB_HALT_WORD) begin
            o = CDB_OP_HALT;
        end else if (w[`CDB_OP_HI:`CDB_OP_LO] == `CDB_OPC_DEC_FILE) begin
            o = CDB_OP_DEC_FILE;
        end else if (w[`CDB_OP_HI:`CDB_OP_LO] == `CDB_OPC_DEC_SKIP) begin
            o = CDB_OP_DEC_SKIP;
        end
        return o;
    endfunction

    function automatic logic [7:0] dec8(input logic [7:0] v);
        return v - `CDB_ONE8;
    endfunction

    cdb_wake u_wake (
        .clk_i(CORE_CLK_I),
        .rst_i(SRST_I),
        .src_i(IRQ_SRC_I),
        .en_i(IRQ_EN_I),
        .wake_o(wake)
    );

    assign op = decode(ir_q);
    assign result = dec8(FILE_RDATA_I);
    assign exec = (state_q == CDB_ST_EXEC);
    assign live = (bubble_q == CDB_BUB_NONE);
    assign dec_op = (op == CDB_OP_DEC_FILE) || (op == CDB_OP_DEC_SKIP);
    assign PMEM_ADDR_O = pc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            state_q <= CDB_ST_LOAD;
        end else begin
            unique case (state_q)
                CDB_ST_LOAD: begin
                    state_q <= CDB_ST_EXEC;
                end
                CDB_ST_EXEC: begin
                    if (live && op == CDB_OP_HALT) begin
                        state_q <= CDB_ST_HALT;
                    end else begin
                        state_q <= CDB_ST_LOAD;
                    end
                end
                CDB_ST_HALT: begin
                    if (wake) begin
                        state_q <= CDB_ST_LOAD;
                    end
                end
            endcase
        end
    end

    // Discard slot after a taken skip or a jump
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            bubble_q <= CDB_BUB_NONE;
        end else if (exec) begin
            if (!live) begin
                bubble_q <= CDB_BUB_NONE;
            end else if (op == CDB_OP_DEC_SKIP && result == `CDB_ZERO8) begin
                bubble_q <= CDB_BUB_SKIP;
            end else if (op == CDB_OP_JMP) begin
                bubble_q <= CDB_BUB_JUMP;
            end else begin
                bubble_q <= CDB_BUB_NONE;
            end
        end
    end

    // Program counter
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            pc_q <= `CDB_PC_RST;
        end else if (exec) begin
            if (live && op == CDB_OP_JMP) begin
                pc_q <= ir_q[`CDB_K_HI:0];
            end else if (bubble_q != CDB_BUB_JUMP) begin
                pc_q <= pc_q + `CDB_PC_STEP;
            end
        end else if (state_q == CDB_ST_HALT && wake && GIE_I) begin
            pc_q <= `CDB_VECTOR;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ir_q <= `CDB_HALT_WORD ^ `CDB_HALT_WORD;
            FILE_ADDR_O <= `CDB_ZERO8;
        end else if (state_q == CDB_ST_LOAD) begin
            ir_q <= INSTR_I;
            FILE_ADDR_O <= INSTR_I[`CDB_F_HI:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results and flags
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            FILE_WE_O <= 1'b0;
            FILE_WDATA_O <= `CDB_ZERO8;
        end else begin
            FILE_WE_O <= exec && live && dec_op && ir_q[`CDB_D_BIT];
            if (exec && live && dec_op) begin
                FILE_WDATA_O <= result;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            W_O <= `CDB_W_RST;
        end else if (exec && live && dec_op && !ir_q[`CDB_D_BIT]) begin
            W_O <= result;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ZERO_O <= 1'b0;
        end else if (exec && live && op == CDB_OP_DEC_FILE) begin
            ZERO_O <= (result == `CDB_ZERO8);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt and wake
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            CORE_RUN_O <= 1'b1;
        end else if (exec && live && op == CDB_OP_HALT) begin
            CORE_RUN_O <= 1'b0;
        end else if (state_q == CDB_ST_HALT && wake) begin
            CORE_RUN_O <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            VEC_TAKE_O <= 1'b0;
            RETURN_ADDR_O <= `CDB_PC_RST;
        end else begin
            VEC_TAKE_O <= (state_q == CDB_ST_HALT) && wake && GIE_I;
            if (state_q == CDB_ST_HALT && wake && GIE_I) begin
                RETURN_ADDR_O <= pc_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            INSTR_DONE_O <= 1'b0;
        end else begin
            INSTR_DONE_O <= exec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    property p_dec_zero;
        exec && live && op == CDB_OP_DEC_FILE |=> ZERO_O == ($past(result) == `CDB_ZERO8);
    endproperty
    a_dec_zero: assert property (p_dec_zero) else $error("zero flag wrong after decrement");

    property p_dec_to_w;
        exec && live && op == CDB_OP_DEC_FILE && !ir_q[`CDB_D_BIT] |=> W_O == $past(result) && !FILE_WE_O;
    endproperty
    a_dec_to_w: assert property (p_dec_to_w) else $error("decrement to W misrouted");

    property p_dec_to_file;
        exec && live && dec_op && ir_q[`CDB_D_BIT] |=> FILE_WE_O && FILE_WDATA_O == $past(result);
    endproperty
    a_dec_to_file: assert property (p_dec_to_file) else $error("decrement to file misrouted");

    property p_dec_skip_flags;
        exec && live && op == CDB_OP_DEC_SKIP |=> $stable(ZERO_O);
    endproperty
    a_dec_skip_flags: assert property (p_dec_skip_flags) else $error("skip decrement touched flag");

    sequence s_skip_taken;
        exec && live && op == CDB_OP_DEC_SKIP && result == `CDB_ZERO8;
    endsequence
    sequence s_discard_slot;
        !exec ##1 (exec && !live);
    endsequence
    property p_skip;
        s_skip_taken |=> s_discard_slot ##1 (pc_q == $past(pc_q, 3) + `CDB_PC_SKIP && !FILE_WE_O);
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not discard next instruction");

    sequence s_skip_missed;
        exec && live && op == CDB_OP_DEC_SKIP && result != `CDB_ZERO8;
    endsequence
    property p_no_skip;
        s_skip_missed |=> !exec ##1 (exec && live);
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip taken on nonzero result");

    property p_jump;
        exec && live && op == CDB_OP_JMP |=> pc_q == $past(ir_q[`CDB_K_HI:0]) && $stable(ZERO_O)
            ##2 pc_q == $past(ir_q[`CDB_K_HI:0], 3);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or timing wrong");

    property p_halt;
        exec && live && op == CDB_OP_HALT |=> !CORE_RUN_O && state_q == CDB_ST_HALT && $stable(ZERO_O);
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop core");

    property p_halt_hold;
        state_q == CDB_ST_HALT && !wake |=> state_q == CDB_ST_HALT && $stable(pc_q) && !CORE_RUN_O;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("core left halt without wake");

    property p_wake;
        state_q == CDB_ST_HALT && wake |=> CORE_RUN_O && state_q == CDB_ST_LOAD;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restart core");

    property p_resume;
        state_q == CDB_ST_HALT && wake && !GIE_I |=> pc_q == $past(pc_q) && !VEC_TAKE_O;
    endproperty
    a_resume: assert property (p_resume) else $error("resume address wrong");

    property p_vector;
        state_q == CDB_ST_HALT && wake && GIE_I |=> pc_q == `CDB_VECTOR && VEC_TAKE_O
            && RETURN_ADDR_O == $past(pc_q);
    endproperty
    a_vector: assert property (p_vector) else $error("vector not taken");
endmodule

/* rtl/cdb_regs.svh */
// Purpose: named constants for the decrement / branch / halt execution core
// Assumes: 16-bit instruction word, 13-bit program counter, 8-bit file data
// Notes: opcode encodings are local choices
`ifndef CDB_REGS_SVH
`define CDB_REGS_SVH

// Instruction word fields
`define CDB_JMP_HI 15
`define CDB_JMP_LO 13
`define CDB_K_HI 12
`define CDB_OP_HI 15
`define CDB_OP_LO 9
`define CDB_D_BIT 8
`define CDB_F_HI 7

// Encodings
`define CDB_OPC_JMP 3'h1
`define CDB_OPC_DEC_FILE 7'h03
`define CDB_OPC_DEC_SKIP 7'h0B
`define CDB_HALT_WORD 16'h0001

// Reset values and arithmetic constants
`define CDB_PC_RST 13'h0000
`define CDB_VECTOR 13'h0004
`define CDB_W_RST 8'h00
`define CDB_ZERO8 8'h00
`define CDB_ONE8 8'h01
`define CDB_PC_STEP 13'h0001
`define CDB_PC_SKIP 13'h0002

`endif

/* rtl/cdb_pkg.sv */
// Purpose: types shared by the execution core
// Assumes: nothing
// Notes: state codes are one-hot
package cdb_pkg;
    typedef enum logic [2:0] {
        CDB_ST_LOAD = 3'b001,
        CDB_ST_EXEC = 3'b010,
        CDB_ST_HALT = 3'b100
    } cdb_state_t;

    typedef enum logic [1:0] {
        CDB_BUB_NONE = 2'h0,
        CDB_BUB_SKIP = 2'h1,
        CDB_BUB_JUMP = 2'h2
    } cdb_bubble_t;

    typedef enum logic [2:0] {
        CDB_OP_NOP = 3'h0,
        CDB_OP_DEC_FILE = 3'h1,
        CDB_OP_DEC_SKIP = 3'h2,
        CDB_OP_JMP = 3'h3,
        CDB_OP_HALT = 3'h4
    } cdb_op_t;
endpackage

/* rtl/cdb_wake.sv */
// Purpose: registered wake request from enabled interrupt sources
// Assumes: sources and enables synchronous to the core clock
// Notes: one clock of latency
`timescale 1ns/10ps
module cdb_wake (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] en_i,
    output logic wake_o
);
    import cdb_pkg::*;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= |(src_i & en_i);
        end
    end
endmodule

/* verification/cdb_mem_model.sv */
// Purpose: program memory and file registers facing the execution core
// Assumes: combinational reads, file write on the rising clock edge
// Notes: program space aliases every 32 words
`timescale 1ns/10ps
module cdb_mem_model (
    input wire logic clk_i,
    input wire logic [12:0] pmem_addr_i,
    input wire logic [7:0] file_addr_i,
    input wire logic [7:0] file_wdata_i,
    input wire logic file_we_i,
    output logic [15:0] instr_o,
    output logic [7:0] file_rdata_o
);
    logic [15:0] prog [0:31];
    logic [7:0] regs [0:255];
    assign instr_o = prog[pmem_addr_i[4:0]];
    assign file_rdata_o = regs[file_addr_i];
    always @(posedge clk_i) begin
        if (file_we_i) begin
            regs[file_addr_i] <= file_wdata_i;
        end
    end
endmodule

/* verification/cpu_decrement_branch_halt_exec_test.sv */
// Purpose: self-checking bench for the execution core
// Assumes: one program runs through every scenario in order
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
module cpu_decrement_branch_halt_exec_test;
    logic clk, srst, gie, run, we, z, vec, done;
    logic [7:0] src, en, faddr, wdata, w, rdata;
    logic [12:0] pc, ret;
    logic [15:0] instr;
    int miscompares = 0;
    int checked = 0;
    cdb_core cdb_core_i (.CORE_CLK_I(clk), .SRST_I(srst), .INSTR_I(instr), .FILE_RDATA_I(rdata),
        .IRQ_SRC_I(src), .IRQ_EN_I(en), .GIE_I(gie), .PMEM_ADDR_O(pc), .FILE_ADDR_O(faddr),
        .FILE_WDATA_O(wdata), .FILE_WE_O(we), .W_O(w), .ZERO_O(z), .CORE_RUN_O(run),
        .VEC_TAKE_O(vec), .RETURN_ADDR_O(ret), .INSTR_DONE_O(done));
    cdb_mem_model cdb_mem_model_i (.clk_i(clk), .pmem_addr_i(pc), .file_addr_i(faddr),
        .file_wdata_i(wdata), .file_we_i(we), .instr_o(instr), .file_rdata_o(rdata));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Next instruction-cycle completion, bounded
    task automatic step();
        int n;
        n = 0;
        @(negedge clk);
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) begin
            miscompares++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_dec_file();
        step();
        chk("faddr", faddr, 16'h0010);
        chk("we", we, 16'h0001);
        chk("wdata", wdata, 16'h0000);
        chk("zero", z, 16'h0001);
        chk("pc", pc, 16'h0001);
        step();
        chk("w", w, 16'h0022);
        chk("zero", z, 16'h0000);
        chk("we", we, 16'h0000);
    endtask
    task automatic t_dec_skip();
        step();
        chk("we", we, 16'h0001);
        chk("wdata", wdata, 16'h0000);
        chk("zero", z, 16'h0000);
        chk("pc", pc, 16'h0003);
        step();
        chk("we", we, 16'h0000);
        chk("pc", pc, 16'h0004);
        chk("w", w, 16'h0022);
    endtask
    task automatic t_jump();
        step();
        chk("pc", pc, 16'h0010);
        chk("zero", z, 16'h0000);
        @(negedge clk);
        chk("done", done, 16'h0000);
        step();
        chk("pc", pc, 16'h0010);
        chk("we", we, 16'h0000);
    endtask
    task automatic t_halt(input logic g);
        int n;
        step();
        chk("run", run, 16'h0000);
        chk("pc", pc, 16'h0011);
        chk("zero", z, 16'h0000);
        src = 8'h04;
        repeat (6) @(negedge clk);
        chk("run", run, 16'h0000);
        en = 8'h04;
        gie = g;
        n = 0;
        while (run !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            miscompares++;
            end_sim();
        end
        chk("run", run, 16'h0001);
        chk("vec", vec, {15'h0000, g});
        chk("pc", pc, g ? 16'h0004 : 16'h0011);
        if (g) begin
            chk("ret", ret, 16'h0011);
        end
        src = 8'h00;
        en = 8'h00;
    endtask
    // Resume after halt without vector
    task automatic t_resume();
        chk("skipped", cdb_mem_model_i.regs[8'h13], 16'h0005);
        chk("file", cdb_mem_model_i.regs[8'h10], 16'h0000);
        chk("file", cdb_mem_model_i.regs[8'h12], 16'h0000);
        step();
        chk("w", w, 16'h007F);
        chk("pc", pc, 16'h0012);
    endtask
    // Skip decrement to W with nonzero result, then jump back
    task automatic t_skip_miss();
        step();
        chk("w", w, 16'h0041);
        chk("we", we, 16'h0000);
        chk("zero", z, 16'h0000);
        chk("pc", pc, 16'h0013);
        step();
        step();
        chk("pc", pc, 16'h0010);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        gie = 1'b0;
        src = 8'h00;
        en = 8'h00;
        for (int i = 0; i < 32; i++) begin
            cdb_mem_model_i.prog[i] = 16'h0000;
        end
        cdb_mem_model_i.prog[0] = 16'h0710;
        cdb_mem_model_i.prog[1] = 16'h0611;
        cdb_mem_model_i.prog[2] = 16'h1712;
        cdb_mem_model_i.prog[3] = 16'h0713;
        cdb_mem_model_i.prog[4] = 16'h2010;
        cdb_mem_model_i.prog[16] = 16'h0001;
        cdb_mem_model_i.prog[17] = 16'h0614;
        cdb_mem_model_i.prog[18] = 16'h1615;
        cdb_mem_model_i.prog[19] = 16'h2010;
        cdb_mem_model_i.regs[8'h10] = 8'h01;
        cdb_mem_model_i.regs[8'h11] = 8'h23;
        cdb_mem_model_i.regs[8'h12] = 8'h01;
        cdb_mem_model_i.regs[8'h13] = 8'h05;
        cdb_mem_model_i.regs[8'h14] = 8'h80;
        cdb_mem_model_i.regs[8'h15] = 8'h42;
        repeat (4) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        t_dec_file();
        t_dec_skip();
        t_jump();
        t_halt(1'b0);
        t_resume();
        t_skip_miss();
        t_halt(1'b1);
        end_sim();
    end
endmodule
